// file: hw/rac_map.vh
// register map, field positions, reset values and counts of the reset/interrupt controller
`ifndef RAC_MAP_VH
`define RAC_MAP_VH

// ------------------------------------------------------------
// register indexes (byte address = 4 * index)
// ------------------------------------------------------------
`define RAC_IDX_EN_MAIN      8'h23
`define RAC_IDX_EN_BUF_LO    8'h24
`define RAC_IDX_EN_BUF_HI    8'h25
`define RAC_IDX_FL_MAIN      8'h26
`define RAC_IDX_FL_BUF_LO    8'h27
`define RAC_IDX_FL_BUF_HI    8'h28
`define RAC_IDX_STATUS       8'h2c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RAC_GIE_BIT          7
`define RAC_ST_DIP_BIT       7
`define RAC_ST_SLEEP_BIT     6
`define RAC_ST_IDLE_BIT      4
`define RAC_ST_STACK_BIT     2
`define RAC_MAIN_SRC_W       7
`define RAC_BUF_HI_W         3
`define RAC_FLAG_W           18

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RAC_EN_RESET         8'h00
`define RAC_FLAG_RESET       18'h00000
`define RAC_STATUS_FULL      4'h8
`define RAC_PC_RESET         11'h000
`define RAC_PC_VECTOR        11'h004

// ------------------------------------------------------------
// start-up counts, in oscillator cycles
// ------------------------------------------------------------
`define RAC_LS_DELAY         12'h800
`define RAC_HS_DELAY         12'h400
`define RAC_CNT_ONE          12'h001
`define RAC_CNT_ZERO         12'h000

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define RAC_RESP_OKAY        2'b00
`define RAC_RESP_SLVERR      2'b10
`define RAC_DATA_ZERO        32'h00000000

`endif

// file: hw/rac_reset_irq_ctrl.v
// reset sequencing, reset-cause status and two-level interrupt gating
//
// What this block does
// - exactly two reset sources: supply dip and stack fault
// - after any reset release the core fetches from address zero
// - supply-dip reset is full; release waits for oscillator start-up count
// - stack-fault reset is partial and skips the start-up count
// - reset held while supply is low, released once it recovers
// - supply-dip reset path cannot be disabled by software
// - supply-dip reset sets status bit 7
// - stack overflow or underflow raises stack-fault reset, sets status bit 2
// - full reset: bit 7 one, bits 6,4,2 zero; stack fault sets bit 2 only
// - start-up delay is 2048 slow then 1024 fast oscillator cycles
// - supply dip acts in run, idle, sleep; stack fault only in run
// - supply-dip flag stays set until reset pin or software clear
// - sleep event sets bit 6; cleared by supply dip, reset pin, software
// - idle event sets bit 4; idle and stack bits cleared by dip or software
// - permitted enabled event redirects program counter to the vector
// - service needs global enable and per-source enable both set
// - writing one opens a source enable, zero closes it
// - vector entry clears the global enable
// - interrupt return sets global enable; plain return leaves it
// - main enable bits: converter, timer B, timer A, recovery, low, pins
// - buffer enables: low register buffers 7..0, high register 10..8
// - event flags read one when happened, same positions as enables
//
// Decided for this implementation: the Avalon-MM slave port.
`include "rac_map.vh"

module rac_reset_irq_ctrl (
   input  wire        clk,
   input  wire        rst_n,
   // register bus
   input  wire [9:0]  avsAddress,
   input  wire        avsRead,
   input  wire        avsWrite,
   input  wire [31:0] avsWriteData,
   input  wire [3:0]  avsByteEnable,
   output reg  [31:0] avsReadData,
   output reg  [1:0]  avsResponse,
   output reg         avsWaitRequest,
   // supply monitor, reset pin and oscillators (asynchronous)
   input  wire        supplyLow,
   input  wire        extResetPin,
   input  wire        lowSpeedOscClk,
   input  wire        highSpeedOscClk,
   // core side (same clock)
   input  wire        stackOverflow,
   input  wire        stackUnderflow,
   input  wire        cpuIdle,
   input  wire        cpuSleep,
   input  wire        sleepEvent,
   input  wire        idleEvent,
   input  wire        returnFromInterrupt,
   input  wire [6:0]  mainEvents,
   input  wire [10:0] bufferWriteEvents,
   output reg         coreReset,
   output reg         partialReset,
   output reg         pcLoad,
   output reg  [10:0] pcLoadAddr
);

   // ------------------------------------------------------------
   // reset sequencer states
   // ------------------------------------------------------------
   localparam [4:0] ST_DIP  = 5'b00001;
   localparam [4:0] ST_LS   = 5'b00010;
   localparam [4:0] ST_HS   = 5'b00100;
   localparam [4:0] ST_PART = 5'b01000;
   localparam [4:0] ST_RUN  = 5'b10000;
   reg [4:0]  state_r;
   reg [4:0]  state_nxt;
   reg [11:0] cnt_r;
   reg [11:0] cnt_nxt;
   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   reg [1:0] lowSync_r;
   reg [1:0] pinSync_r;
   reg [1:0] lsSync_r;
   reg [1:0] hsSync_r;
   reg       lsLast_r;
   reg       hsLast_r;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // supply counted as low until seen otherwise
         lowSync_r <= 2'b11;
         pinSync_r <= 2'b00;
         lsSync_r  <= 2'b00;
         hsSync_r  <= 2'b00;
         lsLast_r  <= 1'b0;
         hsLast_r  <= 1'b0;
      end
      else
      begin
         lowSync_r <= {lowSync_r[0], supplyLow};
         pinSync_r <= {pinSync_r[0], extResetPin};
         lsSync_r  <= {lsSync_r[0], lowSpeedOscClk};
         hsSync_r  <= {hsSync_r[0], highSpeedOscClk};
         lsLast_r  <= lsSync_r[1];
         hsLast_r  <= hsSync_r[1];
      end
   end
   wire supplyDip = lowSync_r[1];
   wire pinEvent  = pinSync_r[1];
   wire lsTick    = lsSync_r[1] & ~lsLast_r;
   wire hsTick    = hsSync_r[1] & ~hsLast_r;
   wire stackFault = (stackOverflow | stackUnderflow) & (state_r == ST_RUN) &
                     ~cpuIdle & ~cpuSleep;

   // ------------------------------------------------------------
   // reset sequencer
   // ------------------------------------------------------------
   always @*
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_DIP:
         begin
            if (!supplyDip)
            begin
               state_nxt = ST_LS;
               cnt_nxt   = `RAC_LS_DELAY;
            end
         end
         ST_LS:
         begin
            if (lsTick && cnt_r == `RAC_CNT_ONE)
            begin
               state_nxt = ST_HS;
               cnt_nxt   = `RAC_HS_DELAY;
            end
            else if (lsTick)
               cnt_nxt = cnt_r - `RAC_CNT_ONE;
         end
         ST_HS:
         begin
            // release only after the count ends
            if (hsTick && cnt_r == `RAC_CNT_ONE)
               state_nxt = ST_RUN;
            else if (hsTick)
               cnt_nxt = cnt_r - `RAC_CNT_ONE;
         end
         ST_PART:
            state_nxt = ST_RUN;
         ST_RUN:
         begin
            if (stackFault)
               state_nxt = ST_PART;
         end
         default:
            state_nxt = ST_DIP;
      endcase
      // dip path has no enable and beats everything
      if (supplyDip)
      begin
         state_nxt = ST_DIP;
         cnt_nxt   = `RAC_CNT_ZERO;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_DIP;
         cnt_r   <= `RAC_CNT_ZERO;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end
   wire fullReset  = supplyDip;
   wire restartNow = (state_r != ST_RUN) & (state_nxt == ST_RUN);
   // ------------------------------------------------------------
   // bus slave: one wait cycle, then a one-cycle answer
   // ------------------------------------------------------------
   wire       busReq  = avsRead | avsWrite;
   wire       busDone = busReq & ~avsWaitRequest;
   wire [7:0] regIdx  = avsAddress[9:2];
   wire       wrLane  = avsWrite & busDone & avsByteEnable[0] &
                        (avsAddress[1:0] == 2'b00);
   wire [7:0] wrByte  = avsWriteData[7:0];
   wire wrEnMain  = wrLane & (regIdx == `RAC_IDX_EN_MAIN);
   wire wrEnLo    = wrLane & (regIdx == `RAC_IDX_EN_BUF_LO);
   wire wrEnHi    = wrLane & (regIdx == `RAC_IDX_EN_BUF_HI);
   wire wrFlMain  = wrLane & (regIdx == `RAC_IDX_FL_MAIN);
   wire wrFlLo    = wrLane & (regIdx == `RAC_IDX_FL_BUF_LO);
   wire wrFlHi    = wrLane & (regIdx == `RAC_IDX_FL_BUF_HI);
   wire wrStatus  = wrLane & (regIdx == `RAC_IDX_STATUS);
   // ------------------------------------------------------------
   // enables
   // ------------------------------------------------------------
   reg       gie_r;
   reg [6:0] enMain_r;
   reg [7:0] enBufLo_r;
   reg [2:0] enBufHi_r;
   wire      vectorEntry;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gie_r     <= 1'b0;
         enMain_r  <= 7'h00;
         enBufLo_r <= `RAC_EN_RESET;
         enBufHi_r <= 3'h0;
      end
      else if (fullReset)
      begin
         gie_r     <= 1'b0;
         enMain_r  <= 7'h00;
         enBufLo_r <= `RAC_EN_RESET;
         enBufHi_r <= 3'h0;
      end
      else
      begin
         if (wrEnMain)
            enMain_r <= wrByte[6:0];
         if (wrEnLo)
            enBufLo_r <= wrByte;
         if (wrEnHi)
            enBufHi_r <= wrByte[2:0];
         if (vectorEntry)
            gie_r <= 1'b0;
         else if (returnFromInterrupt)
            gie_r <= 1'b1;
         else if (wrEnMain)
            gie_r <= wrByte[`RAC_GIE_BIT];
      end
   end

   // ------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------
   reg  [17:0] flags_r;
   wire [17:0] events  = {bufferWriteEvents, mainEvents};
   wire [17:0] enables = {enBufHi_r, enBufLo_r, enMain_r};
   // write-zero clears, one leaves alone
   wire [17:0] clrMask = {(wrFlHi ? ~wrByte[2:0] : 3'h0),
                          (wrFlLo ? ~wrByte : 8'h00),
                          (wrFlMain ? ~wrByte[6:0] : 7'h00)};

   genvar i;
   generate
      for (i = 0; i < `RAC_FLAG_W; i = i + 1)
      begin : g_flag
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               flags_r[i] <= 1'b0;
            else if (fullReset)
               flags_r[i] <= 1'b0;
            // set ignores enables and wins over clear
            else if (events[i])
               flags_r[i] <= 1'b1;
            // only software or a full reset clears, vectoring does not
            else if (clrMask[i])
               flags_r[i] <= 1'b0;
         end
      end
   endgenerate
   wire irqPending = gie_r & (|(flags_r & enables));
   // redirect only from run; a dip in the same cycle wins
   assign vectorEntry = irqPending & (state_r == ST_RUN) & ~stackFault & ~pcLoad & ~supplyDip;
   // ------------------------------------------------------------
   // reset-cause status
   // ------------------------------------------------------------
   reg stDip_r;
   reg stSleep_r;
   reg stIdle_r;
   reg stStack_r;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // power-up counts as a full reset
         stDip_r   <= 1'b1;
         stSleep_r <= 1'b0;
         stIdle_r  <= 1'b0;
         stStack_r <= 1'b0;
      end
      else if (fullReset)
      begin
         // full reset leaves only the dip flag
         stDip_r   <= 1'b1;
         stSleep_r <= 1'b0;
         stIdle_r  <= 1'b0;
         stStack_r <= 1'b0;
      end
      else
      begin
         // dip flag cleared by pin or zero write
         if (pinEvent || (wrStatus && !wrByte[`RAC_ST_DIP_BIT]))
            stDip_r <= 1'b0;
         if (sleepEvent)
            stSleep_r <= 1'b1;
         else if (pinEvent || (wrStatus && !wrByte[`RAC_ST_SLEEP_BIT]))
            stSleep_r <= 1'b0;
         if (idleEvent)
            stIdle_r <= 1'b1;
         else if (wrStatus && !wrByte[`RAC_ST_IDLE_BIT])
            stIdle_r <= 1'b0;
         // stack fault sets only its own bit
         if (stackFault)
            stStack_r <= 1'b1;
         else if (wrStatus && !wrByte[`RAC_ST_STACK_BIT])
            stStack_r <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // read mux and bus answer
   // ------------------------------------------------------------
   reg [7:0] rdByte;
   reg       rdHit;
   always @*
   begin
      rdByte = 8'h00;
      rdHit  = (avsAddress[1:0] == 2'b00);
      case (regIdx)
         `RAC_IDX_EN_MAIN:   rdByte = {gie_r, enMain_r};
         `RAC_IDX_EN_BUF_LO: rdByte = enBufLo_r;
         `RAC_IDX_EN_BUF_HI: rdByte = {5'h00, enBufHi_r};
         `RAC_IDX_FL_MAIN:   rdByte = {1'b0, flags_r[6:0]};
         `RAC_IDX_FL_BUF_LO: rdByte = flags_r[14:7];
         `RAC_IDX_FL_BUF_HI: rdByte = {5'h00, flags_r[17:15]};
         `RAC_IDX_STATUS:
            rdByte = {stDip_r, stSleep_r, 1'b0, stIdle_r, 1'b0, stStack_r, 2'b00};
         default:            rdHit = 1'b0;
      endcase
   end
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         avsWaitRequest <= 1'b1;
         avsReadData    <= `RAC_DATA_ZERO;
         avsResponse    <= `RAC_RESP_OKAY;
      end
      else
      begin
         // low for exactly one cycle per request
         avsWaitRequest <= ~(busReq & avsWaitRequest);
         if (busReq && avsWaitRequest)
         begin
            avsReadData <= avsRead ? {24'h000000, rdByte} : `RAC_DATA_ZERO;
            avsResponse <= rdHit ? `RAC_RESP_OKAY : `RAC_RESP_SLVERR;
         end
      end
   end
   // ------------------------------------------------------------
   // core outputs
   // ------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         coreReset    <= 1'b1;
         partialReset <= 1'b0;
         pcLoad       <= 1'b0;
         pcLoadAddr   <= `RAC_PC_RESET;
      end
      else
      begin
         // only these two sources drive core reset
         coreReset    <= (state_nxt != ST_RUN);
         partialReset <= (state_nxt == ST_PART);
         // restart from zero on release; address holds between loads
         pcLoad       <= restartNow | vectorEntry;
         if (restartNow)
            pcLoadAddr <= `RAC_PC_RESET;
         else if (vectorEntry)
            pcLoadAddr <= `RAC_PC_VECTOR;
      end
   end

endmodule // rac_reset_irq_ctrl

// file: bench/rac_reset_irq_ctrl_props.sv
// concurrent checks on the reset/interrupt controller ports
module rac_reset_irq_ctrl_props (
   input wire        clk,
   input wire        rst_n,
   input wire        avsRead,
   input wire        avsWrite,
   input wire        avsWaitRequest,
   input wire        supplyLow,
   input wire        stackOverflow,
   input wire        stackUnderflow,
   input wire        cpuIdle,
   input wire        cpuSleep,
   input wire        coreReset,
   input wire        partialReset,
   input wire        pcLoad,
   input wire [10:0] pcLoadAddr
);
   logic [15:0] upCnt;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence vecEntry;
      pcLoad && pcLoadAddr == 11'h004;
   endsequence
   sequence restart;
      pcLoad && pcLoadAddr == 11'h000;
   endsequence
   sequence stackHit;
      (stackOverflow || stackUnderflow) && !coreReset;
   endsequence
   // ------------------------------------------------------------
   // full-reset hold counter
   // ------------------------------------------------------------
   // an oscillator edge needs two clocks at least to pass the sync
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
         upCnt <= 16'h0000;
      else if (supplyLow || !coreReset)
         upCnt <= 16'h0000;
      else if (upCnt != 16'hffff)
         upCnt <= upCnt + 16'h0001;
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   chk_wait_single: assert property (
      (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest ##1 avsWaitRequest)
      else $error("wait request not one cycle");
   chk_restart_zero: assert property (
      $fell(coreReset) |-> restart)
      else $error("restart not at address zero");
   chk_no_vector_reset: assert property (
      coreReset |-> !pcLoad)
      else $error("pc load during reset");
   chk_load_one_cycle: assert property (
      pcLoad |=> !pcLoad)
      else $error("pc load longer than a cycle");
   chk_partial_brief: assert property (
      $rose(partialReset) |=> (!partialReset && !coreReset) and restart)
      else $error("partial reset not brief");
   chk_stack_in_run: assert property (
      stackHit ##0 (!cpuIdle && !cpuSleep) |=> partialReset && coreReset)
      else $error("stack fault ignored in run");
   chk_stack_not_idle: assert property (
      stackHit ##0 (cpuIdle || cpuSleep) |=> !partialReset)
      else $error("stack fault taken outside run");
   chk_dip_holds: assert property (
      supplyLow [*4] |-> coreReset && !partialReset)
      else $error("reset not held in supply dip");
   chk_vector_once: assert property (
      vecEntry |=> (!(pcLoad && pcLoadAddr == 11'h004)) [*3])
      else $error("vector entered again");
   chk_startup_floor: assert property (
      $fell(coreReset) && !$past(partialReset) |-> upCnt >= 16'h1800)
      else $error("full reset released too early");
endmodule // rac_reset_irq_ctrl_props

bind rac_reset_irq_ctrl rac_reset_irq_ctrl_props rac_reset_irq_ctrl_props_i (
   .clk, .rst_n, .avsRead, .avsWrite, .avsWaitRequest, .supplyLow, .stackOverflow,
   .stackUnderflow, .cpuIdle, .cpuSleep, .coreReset, .partialReset, .pcLoad, .pcLoadAddr);

// file: bench/rac_core_model.sv
// behavioural core: follows pc loads and issues interrupt returns
module rac_core_model (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         coreReset,
   input  wire         pcLoad,
   input  wire  [10:0] pcLoadAddr,
   input  wire         retReq,
   input  wire         slow,
   output logic        returnFromInterrupt,
   output logic [10:0] pc,
   output int          vecCount,
   output int          rstCount
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] pend;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend <= 3'h0;
         returnFromInterrupt <= 1'b0;
         pc <= 11'h000;
         vecCount <= 0;
         rstCount <= 0;
      end
      else
      begin
         pend <= {pend[1:0], retReq};
         // interrupt return
         // never while held in reset; a slow core answers three cycles late
         returnFromInterrupt <= !coreReset && (slow ? pend[2] : retReq);
         if (pcLoad)
            pc <= pcLoadAddr;
         if (pcLoad && pcLoadAddr == 11'h004)
            vecCount <= vecCount + 1;
         if (pcLoad && pcLoadAddr == 11'h000)
            rstCount <= rstCount + 1;
      end
   end
endmodule // rac_core_model

// file: bench/rac_reset_irq_ctrl_tb.sv
// self-checking bench for the reset/interrupt controller
`include "rac_map.vh"
module rac_reset_irq_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int StartCyc = (2048 * 50 + 1024 * 30) / 10;
   logic        clk = 0, rst_n = 0, avsRead = 0, avsWrite = 0;
   logic [9:0]  avsAddress = 0;
   logic [31:0] avsWriteData = 0, avsReadData, q;
   logic [1:0]  avsResponse, r;
   logic        avsWaitRequest, coreReset, partialReset, pcLoad, returnFromInterrupt;
   logic        supplyLow = 0, extResetPin = 0, lsOsc = 0, hsOsc = 0, retReq = 0, slow = 0;
   logic        stackOverflow = 0, stackUnderflow = 0, cpuIdle = 0, cpuSleep = 0;
   logic        sleepEvent = 0, idleEvent = 0;
   logic [17:0] ev = 0, e;
   logic [10:0] pcLoadAddr, pc;
   int          vecCount, rstCount, v, t0, bad_count = 0, check_count = 0, cycles = 0;
   always #5 clk = ~clk;
   always #25 lsOsc = ~lsOsc;
   always #15 hsOsc = ~hsOsc;
   rac_reset_irq_ctrl rac_reset_irq_ctrl_i (.clk, .rst_n, .avsAddress, .avsRead, .avsWrite,
      .avsWriteData, .avsByteEnable(4'hf), .avsReadData, .avsResponse, .avsWaitRequest,
      .supplyLow, .extResetPin, .lowSpeedOscClk(lsOsc), .highSpeedOscClk(hsOsc), .stackOverflow,
      .stackUnderflow, .cpuIdle, .cpuSleep, .sleepEvent, .idleEvent, .returnFromInterrupt,
      .mainEvents(ev[6:0]), .bufferWriteEvents(ev[17:7]), .coreReset, .partialReset,
      .pcLoad, .pcLoadAddr);
   rac_core_model rac_core_model_i (.clk, .rst_n, .coreReset, .pcLoad, .pcLoadAddr, .retReq,
      .slow, .returnFromInterrupt, .pc, .vecCount, .rstCount);
   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      avsAddress <= {idx, 2'b00};
      avsWrite <= w;
      avsRead <= !w;
      avsWriteData <= {24'h000000, d};
      @(posedge clk);
      while (avsWaitRequest !== 1'b0)
         @(posedge clk);
      q = avsReadData;
      r = avsResponse;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x)
      begin
         $display("unexpected %s: expected %h seen %h", nm, x, g);
         bad_count++;
      end
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] x);
      acc(1'b0, idx, 8'h00);
      chk("response", `RAC_RESP_OKAY, r);
      chk("readData", {24'h000000, x}, q);
   endtask
   task automatic setEn(input logic [17:0] en, input logic g);
      acc(1'b1, `RAC_IDX_EN_MAIN, {g, en[6:0]});
      acc(1'b1, `RAC_IDX_EN_BUF_LO, en[14:7]);
      acc(1'b1, `RAC_IDX_EN_BUF_HI, {5'h00, en[17:15]});
   endtask
   task automatic fire(input logic [17:0] x);
      @(posedge clk);
      ev <= x;
      @(posedge clk);
      ev <= 18'h00000;
   endtask
   task automatic waitRestart(input int lo, input int hi);
      while (rstCount == v)
         @(posedge clk);
      chk("restartInWindow", 32'h1, (cycles - t0 >= lo) && (cycles - t0 <= hi));
      chk("restartAddr", `RAC_PC_RESET, pc);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // a hang ends the run as a mismatch
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         bad_count++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      v = rstCount;
      t0 = cycles;
      rd(`RAC_IDX_STATUS, 8'h80);
      for (int i = 0; i < 6; i++)
         rd(8'(`RAC_IDX_EN_MAIN + i), 8'h00);
      acc(1'b0, 8'h29, 8'h00);
      chk("unmappedResp", `RAC_RESP_SLVERR, r);
      waitRestart(StartCyc - 12, StartCyc + 40);
      fire(18'h3ffff);
      rd(`RAC_IDX_FL_MAIN, 8'h7f);
      rd(`RAC_IDX_FL_BUF_LO, 8'hff);
      rd(`RAC_IDX_FL_BUF_HI, 8'h07);
      for (int k = 0; k < 3; k++)
      begin
         acc(1'b1, 8'(`RAC_IDX_FL_MAIN + k), 8'h00);
         rd(8'(`RAC_IDX_FL_MAIN + k), 8'h00);
      end
      setEn(18'h0ad5a, 1'b0);
      rd(`RAC_IDX_EN_MAIN, 8'h5a);
      rd(`RAC_IDX_EN_BUF_LO, 8'h5a);
      rd(`RAC_IDX_EN_BUF_HI, 8'h01);
      acc(1'b1, `RAC_IDX_STATUS, 8'hff);
      rd(`RAC_IDX_STATUS, 8'h80);
      sleepEvent <= 1'b1;
      idleEvent <= 1'b1;
      @(posedge clk);
      sleepEvent <= 1'b0;
      idleEvent <= 1'b0;
      rd(`RAC_IDX_STATUS, 8'hd0);
      v = rstCount;
      t0 = cycles;
      stackOverflow <= 1'b1;
      @(posedge clk);
      stackOverflow <= 1'b0;
      waitRestart(1, 5);
      rd(`RAC_IDX_STATUS, 8'hd4);
      rd(`RAC_IDX_EN_MAIN, 8'h5a);
      cpuIdle <= 1'b1;
      stackUnderflow <= 1'b1;
      @(posedge clk);
      stackUnderflow <= 1'b0;
      cpuIdle <= 1'b0;
      rd(`RAC_IDX_STATUS, 8'hd4);
      extResetPin <= 1'b1;
      repeat (4) @(posedge clk);
      extResetPin <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`RAC_IDX_STATUS, 8'h14);
      acc(1'b1, `RAC_IDX_STATUS, 8'hef);
      rd(`RAC_IDX_STATUS, 8'h04);
      // each source: wrong enable, no global enable, then both gates open
      for (int i = 0; i < 18; i++)
      begin
         e = 18'h00001 << i;
         setEn(18'h00001 << ((i + 1) % 18), 1'b1);
         fire(e);
         v = vecCount;
         repeat (4) @(posedge clk);
         setEn(e, 1'b0);
         chk("noVector", v, vecCount);
         setEn(e, 1'b1);
         chk("vector", v + 1, vecCount);
         chk("pcAtVector", `RAC_PC_VECTOR, pc);
         rd(`RAC_IDX_EN_MAIN, {1'b0, e[6:0]});
         for (int k = 0; k < 3; k++)
            acc(1'b1, 8'(`RAC_IDX_FL_MAIN + k), 8'h00);
         slow <= i[0];
         retReq <= 1'b1;
         @(posedge clk);
         retReq <= 1'b0;
         repeat (8) @(posedge clk);
         rd(`RAC_IDX_EN_MAIN, {1'b1, e[6:0]});
         chk("quietAfterReturn", v + 1, vecCount);
      end
      cpuSleep <= 1'b1;
      supplyLow <= 1'b1;
      repeat (20) @(posedge clk);
      rd(`RAC_IDX_STATUS, 8'h80);
      rd(`RAC_IDX_EN_MAIN, 8'h00);
      v = rstCount;
      t0 = cycles;
      supplyLow <= 1'b0;
      cpuSleep <= 1'b0;
      waitRestart(StartCyc - 12, StartCyc + 40);
      summarize();
   end
endmodule // rac_reset_irq_ctrl_tb
